// *** hw/rsc_pkg.sv ***
// Purpose: shared constants and carriers for the reset strap and host pin block
// Assumes: 20 MHz system clock
// Notes: strap levels are sampled once per power-on reset
package rsc_pkg;

  localparam int CLK_HZ = 20000000;
  localparam int CFG_TIME_MS = 55;
  // configuration window length, exact at this rate
  localparam int CFG_CYCLES = CFG_TIME_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 21;
  // settle cycles after reset release before the straps are caught
  localparam logic [CNT_W-1:0] SETTLE_CYCLES = 21'h000004;
  localparam logic [CNT_W-1:0] CNT_RESET = 21'h000000;

  localparam int GPIO_N = 7;
  localparam int STRAP_MODE_BIT = 3;
  localparam int STRAP_MCLK_LO = 0;
  localparam int STRAP_MCLK_HI = 1;
  // level on the mode strap that picks the serial peripheral port
  localparam logic SPI_MODE_LEVEL = 1'h1;

  typedef enum logic [1:0] {
    RSC_SETTLE = 2'b00,
    RSC_HOLD   = 2'b01,
    RSC_RUN    = 2'b10
  } rsc_phase_t;

  typedef struct packed {
    logic spi_mode;
    logic [1:0] mclk_sel;
  } rsc_straps_t;

  localparam rsc_straps_t STRAPS_RESET = '{spi_mode: 1'h0, mclk_sel: 2'h0};

  // per pin programmed setup from the internal processor
  typedef struct packed {
    logic [GPIO_N-1:0] oe;
    logic [GPIO_N-1:0] val;
    logic [GPIO_N-1:0] irq_sel;
  } rsc_gpio_cfg_t;

  // one two-signal group per gpio bank
  typedef struct packed {
    logic [GPIO_N-1:0] dout;
    logic [GPIO_N-1:0] oe;
  } rsc_gpio_drv_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic cs_n;
  } rsc_spi_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic [1:0] addr_sel;
  } rsc_i2c_t;

  localparam rsc_spi_t SPI_IDLE = '{sck: 1'h0, mosi: 1'h0, cs_n: 1'h1};
  localparam rsc_i2c_t I2C_IDLE = '{scl: 1'h1, sda: 1'h1, addr_sel: 2'h0};

endpackage

// *** hw/rsc_sync.sv ***
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to sys_clk_in
// Notes: first stage is read only by the second stage
module rsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] meta_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    meta_next = d_in;
    q_next = meta_reg;
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      q_reg <= q_next;
    end
  end

  assign q_out = q_reg;

endmodule

// *** hw/rsc_strap_host.sv ***
// Purpose: reset strap capture, gpio ownership and host pin routing
// Assumes: one 20 MHz clock, nrst_in is the power-on reset
// Notes: pins are released until the configuration window has ended
//
// Overview of operation
// - gpio3 strap selects I2C or SPI port
// - gpio1 and gpio0 straps select master clock
// - after window, gpio follow processor configuration
// - shared clock pin: SPI clock or SCL
// - serial input carries command, address, data; SDA
// - gpio set as interrupt output flags events
// - serial output shifts read data; else address select
module rsc_strap_host
  import rsc_pkg::*;
#(
  parameter int CFG_WAIT = rsc_pkg::CFG_CYCLES
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // gpio pins
  input wire logic [rsc_pkg::GPIO_N-1:0] gpio_in,
  output rsc_pkg::rsc_gpio_drv_t gpio_out,
  // internal processor side
  input rsc_pkg::rsc_gpio_cfg_t gpio_cfg_in,
  input wire logic host_irq_in,
  output logic [rsc_pkg::GPIO_N-1:0] gpio_level_out,
  output rsc_pkg::rsc_straps_t straps_out,
  output logic cfg_ready_out,
  // host pins: shared clock, serial in, serial out, select
  input wire logic sck_scl_in,
  output logic sck_scl_out,
  output logic sck_scl_oe_out,
  input wire logic si_sda_in,
  output logic si_sda_out,
  output logic si_sda_oe_out,
  input wire logic host_serial_out_addr_sel_hi_in,
  output logic host_serial_out_addr_sel_hi_out,
  output logic host_serial_out_addr_sel_hi_oe_out,
  input wire logic host_select_n_addr_sel_lo_in,
  // serial port cores
  output rsc_pkg::rsc_spi_t spi_out,
  input wire logic spi_miso_in,
  output rsc_pkg::rsc_i2c_t i2c_out,
  input wire logic i2c_scl_low_in,
  input wire logic i2c_sda_low_in
);

  localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(CFG_WAIT - 1);

  logic [GPIO_N-1:0] gpio_s;
  logic sck_s;
  logic si_s;
  logic so_s;
  logic cs_s;

  rsc_sync #(.W(GPIO_N + 4)) u_sync (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .d_in({gpio_in, sck_scl_in, si_sda_in, host_serial_out_addr_sel_hi_in,
           host_select_n_addr_sel_lo_in}),
    .q_out({gpio_s, sck_s, si_s, so_s, cs_s})
  );

  // phase and strap capture
  rsc_phase_t phase_reg;
  rsc_phase_t phase_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  rsc_straps_t straps_reg;
  rsc_straps_t straps_next;

  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    straps_next = straps_reg;
    case (phase_reg)
      RSC_SETTLE: begin
        // wait out the synchroniser before trusting the straps
        if (cnt_reg == SETTLE_CYCLES) begin
          straps_next.spi_mode = (gpio_s[STRAP_MODE_BIT] == SPI_MODE_LEVEL);
          straps_next.mclk_sel = {gpio_s[STRAP_MCLK_HI], gpio_s[STRAP_MCLK_LO]};
          phase_next = RSC_HOLD;
          cnt_next = CNT_RESET;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      RSC_HOLD: begin
        // the host still drives the straps here, so the pins stay released
        if (cnt_reg == WAIT_LAST) begin
          phase_next = RSC_RUN;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      RSC_RUN: begin
        // straps are never touched again until power-on reset
        phase_next = RSC_RUN;
      end
      default: begin
        phase_next = RSC_SETTLE;
        cnt_next = CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase_reg <= RSC_SETTLE;
      cnt_reg <= CNT_RESET;
      straps_reg <= STRAPS_RESET;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      straps_reg <= straps_next;
    end
  end

  // pin drive and host routing
  rsc_gpio_drv_t gpio_reg;
  rsc_gpio_drv_t gpio_next;
  logic [GPIO_N-1:0] level_reg;
  logic [GPIO_N-1:0] level_next;
  logic ready_reg;
  logic ready_next;
  rsc_spi_t spi_reg;
  rsc_spi_t spi_next;
  rsc_i2c_t i2c_reg;
  rsc_i2c_t i2c_next;
  logic scl_oe_reg;
  logic scl_oe_next;
  logic sda_oe_reg;
  logic sda_oe_next;
  logic so_reg;
  logic so_next;
  logic so_oe_reg;
  logic so_oe_next;
  logic run;
  logic spi;

  always_comb begin
    run = (phase_reg == RSC_RUN);
    spi = straps_reg.spi_mode;
    gpio_next.oe = '0;
    gpio_next.dout = '0;
    level_next = gpio_s;
    ready_next = run;
    spi_next = SPI_IDLE;
    i2c_next = I2C_IDLE;
    scl_oe_next = 1'b0;
    sda_oe_next = 1'b0;
    so_next = 1'b0;
    so_oe_next = 1'b0;
    if (run) begin
      gpio_next.oe = gpio_cfg_in.oe | gpio_cfg_in.irq_sel;
      gpio_next.dout = (gpio_cfg_in.val & ~gpio_cfg_in.irq_sel) |
                       (gpio_cfg_in.irq_sel & {GPIO_N{host_irq_in}});
      if (spi) begin
        spi_next.sck = sck_s;
        spi_next.mosi = si_s;
        spi_next.cs_n = cs_s;
        so_next = spi_miso_in;
        so_oe_next = !cs_s;
      end else begin
        i2c_next.scl = sck_s;
        i2c_next.sda = si_s;
        i2c_next.addr_sel = {so_s, cs_s};
        // open drain: only ever pull low
        scl_oe_next = i2c_scl_low_in;
        sda_oe_next = i2c_sda_low_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gpio_reg <= '0;
      level_reg <= '0;
      ready_reg <= 1'b0;
      spi_reg <= SPI_IDLE;
      i2c_reg <= I2C_IDLE;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      so_reg <= 1'b0;
      so_oe_reg <= 1'b0;
    end else begin
      gpio_reg <= gpio_next;
      level_reg <= level_next;
      ready_reg <= ready_next;
      spi_reg <= spi_next;
      i2c_reg <= i2c_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      so_reg <= so_next;
      so_oe_reg <= so_oe_next;
    end
  end

  assign gpio_out = gpio_reg;
  assign gpio_level_out = level_reg;
  assign straps_out = straps_reg;
  assign cfg_ready_out = ready_reg;
  assign spi_out = spi_reg;
  assign i2c_out = i2c_reg;
  assign sck_scl_out = 1'b0;
  assign sck_scl_oe_out = scl_oe_reg;
  assign si_sda_out = 1'b0;
  assign si_sda_oe_out = sda_oe_reg;
  assign host_serial_out_addr_sel_hi_out = so_reg;
  assign host_serial_out_addr_sel_hi_oe_out = so_oe_reg;

  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_capture;
    (phase_reg == RSC_SETTLE) && (cnt_reg == SETTLE_CYCLES);
  endsequence

  sequence s_run_spi;
    run && spi;
  endsequence

  sequence s_run_i2c;
    run && !spi;
  endsequence

  a_mode_strap_capture: assert property (
    s_capture |=> straps_reg.spi_mode == ($past(gpio_s[STRAP_MODE_BIT]) == SPI_MODE_LEVEL))
    else $error("mode strap not captured from gpio3");
  a_mclk_strap_capture: assert property (
    s_capture |=> straps_reg.mclk_sel == $past(gpio_s[1:0]))
    else $error("clock rate strap not captured from gpio1/0");
  a_straps_held: assert property (
    (phase_reg != RSC_SETTLE) |=> $stable(straps_reg))
    else $error("straps changed after capture");
  a_pins_released: assert property (
    !run |=> gpio_out.oe == '0 || $past(run))
    else $error("gpio driven during configuration window");
  a_gpio_follows_cfg: assert property (
    run |=> gpio_out.oe == $past(gpio_cfg_in.oe | gpio_cfg_in.irq_sel) && cfg_ready_out)
    else $error("gpio enables do not follow configuration");
  a_irq_pin_level: assert property (
    run |=> (gpio_out.dout & $past(gpio_cfg_in.irq_sel)) ==
            ($past(gpio_cfg_in.irq_sel) & {GPIO_N{$past(host_irq_in)}}))
    else $error("interrupt pin does not follow interrupt");
  a_spi_clock_route: assert property (
    s_run_spi |=> spi_out.sck == $past(sck_s) && i2c_out.scl && !sck_scl_oe_out)
    else $error("shared clock pin not routed to spi");
  a_spi_data_in: assert property (
    s_run_spi ##1 s_run_spi |-> spi_out.mosi == $past(si_s) && !si_sda_oe_out)
    else $error("serial input not routed to spi");
  a_spi_read_out: assert property (
    s_run_spi |=> host_serial_out_addr_sel_hi_oe_out == !$past(cs_s) &&
                  host_serial_out_addr_sel_hi_out == $past(spi_miso_in))
    else $error("serial output not driven under select");
  a_i2c_lines: assert property (
    s_run_i2c |=> i2c_out.sda == $past(si_s) && si_sda_oe_out == $past(i2c_sda_low_in) &&
                  !host_serial_out_addr_sel_hi_oe_out)
    else $error("i2c data line misrouted");
  a_ready_timing: assert property (
    (phase_reg == RSC_HOLD) && (cnt_reg == WAIT_LAST) |=> ##1 cfg_ready_out)
    else $error("ready flag late after window");

endmodule

// *** verification/rsc_host_model.sv ***
// Purpose: host and board side of the strap and host pins
// Assumes: bench steers the strap window and the host pin levels
// Notes: released pins fall to their pull levels, gpio6 up, rest down
module rsc_host_model
  import rsc_pkg::*;
(
  // strap window
  input wire logic hold_in,
  input rsc_pkg::rsc_straps_t straps_in,
  // host drive
  input wire logic host_en_in,
  input rsc_pkg::rsc_spi_t spi_in,
  // pins
  output logic [rsc_pkg::GPIO_N-1:0] gpio_out,
  output rsc_pkg::rsc_spi_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // gpio4/5 held low, gpio2 left to its pull-down
  assign gpio_out = hold_in ? {1'h1, 2'h0, straps_in.spi_mode, 1'h0, straps_in.mclk_sel}
                            : 7'h40;
  // idle host lines float to the pull-ups
  assign pins_out = host_en_in ? spi_in : 3'h7;
endmodule

// *** verification/testbench.sv ***
// Purpose: self-checking bench for strap capture and host pin routing
// Assumes: short configuration window through CFG_WAIT
// Notes: inputs change on the falling edge only
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("Error %0t: %s", $time, m); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import rsc_pkg::*;
  localparam int CW = 20;
  int err_total = 0;
  int cmp_count = 0;
  logic sys_clk = 1'h0;
  logic nrst = 1'h0;
  logic hold = 1'h1;
  logic hen = 1'h0;
  logic ahi = 1'h0;
  logic irq = 1'h0;
  logic miso = 1'h0;
  logic scl_lo = 1'h0;
  logic sda_lo = 1'h0;
  rsc_straps_t mst = '0;
  rsc_gpio_cfg_t cfg = '0;
  rsc_spi_t hspi = '1;
  rsc_spi_t hpin, spi;
  rsc_i2c_t i2c;
  rsc_straps_t st;
  rsc_gpio_drv_t gdrv;
  logic [6:0] mlvl, gpin, glvl;
  logic rdy, sck_o, sck_oe, sda_o, sda_oe, so_o, so_oe;
  always #25 sys_clk = ~sys_clk;
  // wire level resolved from every driver
  assign gpin = (gdrv.oe & gdrv.dout) | (~gdrv.oe & mlvl);
  rsc_host_model u_rsc_host_model (.hold_in(hold), .straps_in(mst), .host_en_in(hen),
    .spi_in(hspi), .gpio_out(mlvl), .pins_out(hpin));
  rsc_strap_host #(.CFG_WAIT(CW)) u_rsc_strap_host (.sys_clk_in(sys_clk), .nrst_in(nrst),
    .gpio_in(gpin), .gpio_out(gdrv), .gpio_cfg_in(cfg), .host_irq_in(irq),
    .gpio_level_out(glvl), .straps_out(st), .cfg_ready_out(rdy),
    .sck_scl_in(sck_oe ? sck_o : hpin.sck), .sck_scl_out(sck_o), .sck_scl_oe_out(sck_oe),
    .si_sda_in(sda_oe ? sda_o : hpin.mosi), .si_sda_out(sda_o), .si_sda_oe_out(sda_oe),
    .host_serial_out_addr_sel_hi_in(so_oe ? so_o : ahi),
    .host_serial_out_addr_sel_hi_out(so_o), .host_serial_out_addr_sel_hi_oe_out(so_oe),
    .host_select_n_addr_sel_lo_in(hpin.cs_n), .spi_out(spi), .spi_miso_in(miso),
    .i2c_out(i2c), .i2c_scl_low_in(scl_lo), .i2c_sda_low_in(sda_lo));
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic results;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic boot(input logic [2:0] s);
    int n;
    nrst = 1'h0;
    hold = 1'h1;
    mst = s;
    cfg = '1;
    cyc(16);
    `CHK({gdrv, rdy, st}, 18'h0, "reset outputs")
    `CHK({spi, i2c}, {SPI_IDLE, I2C_IDLE}, "reset host idle")
    nrst = 1'h1;
    cyc(8);
    `CHK(gdrv.oe, 7'h00, "gpio driven in window")
    n = 8;
    while (rdy !== 1'h1 && n < CW + 50) begin
      cyc(1);
      n++;
    end
    `CHK(n >= CW + 5 && n <= CW + 8, 1'b1, "ready delay")
    if (n >= CW + 50)
      results();
    `CHK(st, rsc_straps_t'(s), "captured straps")
    // window over, board lets go of the straps
    hold = 1'h0;
    cfg = '0;
    cyc(5);
    `CHK(st, rsc_straps_t'(s), "straps held")
  endtask
  task automatic gpio_run;
    cfg = '{oe: 7'h0f, val: 7'h05, irq_sel: 7'h10};
    irq = 1'h1;
    cyc(2);
    `CHK(gdrv.oe, 7'h1f, "gpio enables")
    `CHK(gdrv.dout, 7'h15, "irq pin high")
    cyc(3);
    `CHK(glvl, 7'h55, "gpio levels")
    irq = 1'h0;
    cyc(2);
    `CHK(gdrv.dout, 7'h05, "irq pin low")
  endtask
  task automatic spi_run;
    hen = 1'h1;
    hspi = 3'h1;
    sda_lo = 1'h1;
    scl_lo = 1'h1;
    cyc(4);
    `CHK({sck_oe, sda_oe}, 2'h0, "i2c pulls in spi")
    `CHK(i2c, I2C_IDLE, "i2c idle in spi")
    hspi = 3'h6;
    cyc(2);
    `CHK(spi.cs_n, 1'h1, "select too early")
    cyc(1);
    `CHK(spi, rsc_spi_t'(3'h6), "spi pins")
    `CHK(so_oe, 1'h1, "serial out enable")
    miso = 1'h1;
    cyc(1);
    `CHK(so_o, 1'h1, "read bit one")
    miso = 1'h0;
    cyc(1);
    `CHK(so_o, 1'h0, "read bit zero")
    hspi = 3'h1;
    cyc(4);
    `CHK(so_oe, 1'h0, "serial out released")
    {hen, sda_lo, scl_lo} = 3'h0;
  endtask
  task automatic i2c_run;
    hen = 1'h1;
    hspi = 3'h0;
    ahi = 1'h1;
    cyc(4);
    `CHK(i2c, rsc_i2c_t'(4'h2), "i2c lines")
    `CHK(spi, SPI_IDLE, "spi idle in i2c")
    `CHK(so_oe, 1'h0, "address pin input")
    sda_lo = 1'h1;
    cyc(1);
    `CHK(sda_oe, 1'h1, "sda pulled")
    scl_lo = 1'h1;
    cyc(1);
    `CHK(sck_oe, 1'h1, "scl pulled")
    `CHK({sck_o, sda_o}, 2'h0, "open drain lines not low")
    {hen, sda_lo, scl_lo} = 3'h0;
  endtask
  initial begin
    boot(3'h6);
    gpio_run();
    spi_run();
    boot(3'h1);
    i2c_run();
    boot(3'h4);
    boot(3'h3);
    results();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    results();
  end
endmodule
